// ===== dbs_transport.v
// Scan debug transport with debug-bus engine, scratch RAM and interrupt bits.
// Assumes scan pins come from outside the clock domain and cores share the clock.
//
// Behaviour
// - Operation starts on Update-DR; result lands in data at next Capture-DR.
// - Unfinished operation at Capture-DR reports sticky status 3.
// - Code 2 reads address then writes data; complete only after the write.
// - One write scan returns old contents, writes new value, may raise interrupt.
// - Interrupt bit on a write starts the selected core on the program.
// - Halt via program setting halt, jump to resume entry, then interrupt.
// - A halted core at resume entry waits for the interrupt again.
// - Core resumes normal execution only when halt is clear at resume entry.
// - Entry to a debug program first saves core registers s0 and s1.
// - No new operation starts on Update-DR while status is sticky.
// - Operation code 0 does nothing and ignores data.
// - Status 2 reports a failed operation, sticky until bus reset written.
`include "dbs_consts.vh"

module dbs_transport #(
	parameter ADDR_W    = 5,
	parameter SEL_W     = 2,
	parameter NCORE     = 4,
	parameter BUS_CYC   = `DBS_BUS_CYCLES
) (
	input  wire                     clock,
	input  wire                     nrst,
	input  wire                     tck,
	input  wire                     tms,
	input  wire                     tdi,
	output reg                      tdo,
	output reg                      tdo_oe,
	input  wire [NCORE-1:0]         core_halted,
	input  wire [NCORE-1:0]         core_at_resume,
	input  wire [`DBS_RAM_AW-1:0]   core_ram_addr,
	input  wire                     core_ram_we,
	input  wire [31:0]              core_ram_wdata,
	output reg  [31:0]              core_ram_rdata,
	output reg  [NCORE-1:0]         core_debug_int,
	output reg  [NCORE-1:0]         core_save_regs,
	output reg  [NCORE-1:0]         core_resume,
	output reg  [NCORE-1:0]         core_wait,
	output reg  [SEL_W-1:0]         sel_core,
	output wire                     bus_busy
);

	localparam DBUS_W = ADDR_W + `DBS_DATA_W + 2;
	localparam [3:0] S_TLR = 4'h0, S_RTI = 4'h1, S_SELDR = 4'h2, S_CAPDR = 4'h3,
		S_SHDR = 4'h4, S_EX1DR = 4'h5, S_PADR = 4'h6, S_EX2DR = 4'h7, S_UPDR = 4'h8,
		S_SELIR = 4'h9, S_CAPIR = 4'ha, S_SHIR = 4'hb, S_EX1IR = 4'hc, S_PAIR = 4'hd,
		S_EX2IR = 4'he, S_UPIR = 4'hf;
	localparam [7:0] BUS_CNT = BUS_CYC[7:0];
	localparam [5:0] ABITS = ADDR_W[5:0];

	// ****************************************
	// Pin sampling and edge finding
	// ****************************************
	reg  [2:0]                  tck_s_reg;
	reg  [2:0]                  tms_s_reg;
	reg  [2:0]                  tdi_s_reg;
	reg                         tck_lvl_reg;
	reg                         tms_lvl_reg;
	reg                         tdi_lvl_reg;
	wire                        tck_rise;
	wire                        tck_fall;

	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			tck_s_reg   <= 3'h0;
			tms_s_reg   <= 3'h7;
			tdi_s_reg   <= 3'h0;
			tck_lvl_reg <= 1'b0;
			tms_lvl_reg <= 1'b1;
			tdi_lvl_reg <= 1'b0;
		end
		else
		begin
			tck_s_reg <= {tck_s_reg[1:0], tck};
			tms_s_reg <= {tms_s_reg[1:0], tms};
			tdi_s_reg <= {tdi_s_reg[1:0], tdi};
			if (tck_s_reg[1] == tck_s_reg[2])
				tck_lvl_reg <= tck_s_reg[2];
			if (tms_s_reg[1] == tms_s_reg[2])
				tms_lvl_reg <= tms_s_reg[2];
			if (tdi_s_reg[1] == tdi_s_reg[2])
				tdi_lvl_reg <= tdi_s_reg[2];
		end
	end

	assign tck_rise = tck_s_reg[1] & tck_s_reg[2] & ~tck_lvl_reg;
	assign tck_fall = ~tck_s_reg[1] & ~tck_s_reg[2] & tck_lvl_reg;

	// ****************************************
	// Scan state machine
	// ****************************************
	reg  [3:0]                  tap_reg;
	reg  [3:0]                  tap_next;

	always @*
	begin
		tap_next = tap_reg;
		case (tap_reg)
			S_TLR:   tap_next = tms_lvl_reg ? S_TLR : S_RTI;
			S_RTI:   tap_next = tms_lvl_reg ? S_SELDR : S_RTI;
			S_SELDR: tap_next = tms_lvl_reg ? S_SELIR : S_CAPDR;
			S_CAPDR: tap_next = tms_lvl_reg ? S_EX1DR : S_SHDR;
			S_SHDR:  tap_next = tms_lvl_reg ? S_EX1DR : S_SHDR;
			S_EX1DR: tap_next = tms_lvl_reg ? S_UPDR : S_PADR;
			S_PADR:  tap_next = tms_lvl_reg ? S_EX2DR : S_PADR;
			S_EX2DR: tap_next = tms_lvl_reg ? S_UPDR : S_SHDR;
			S_UPDR:  tap_next = tms_lvl_reg ? S_SELDR : S_RTI;
			S_SELIR: tap_next = tms_lvl_reg ? S_TLR : S_CAPIR;
			S_CAPIR: tap_next = tms_lvl_reg ? S_EX1IR : S_SHIR;
			S_SHIR:  tap_next = tms_lvl_reg ? S_EX1IR : S_SHIR;
			S_EX1IR: tap_next = tms_lvl_reg ? S_UPIR : S_PAIR;
			S_PAIR:  tap_next = tms_lvl_reg ? S_EX2IR : S_PAIR;
			S_EX2IR: tap_next = tms_lvl_reg ? S_UPIR : S_SHIR;
			S_UPIR:  tap_next = tms_lvl_reg ? S_SELDR : S_RTI;
			default: tap_next = S_TLR;
		endcase
	end

	// ****************************************
	// Scan registers and status
	// ****************************************
	reg  [`DBS_IR_W-1:0]        ir_reg;
	reg  [`DBS_IR_W-1:0]        ir_sh_reg;
	reg  [DBUS_W-1:0]           dr_sh_reg;
	reg  [1:0]                  stat_reg;
	reg                         err_reg;
	reg                         busy_reg;
	reg  [7:0]                  cnt_reg;
	reg  [1:0]                  bop_reg;
	reg  [ADDR_W-1:0]           baddr_reg;
	reg  [`DBS_DATA_W-1:0]      bwdata_reg;
	reg  [`DBS_DATA_W-1:0]      result_reg;
	wire                        sticky;
	wire                        is_dbus;
	wire                        is_ctrl;
	wire                        start;
	wire                        done;
	wire                        do_write;
	wire                        bus_reset;
	wire [1:0]                  sh_op;
	wire [`DBS_CTRL_W-1:0]      ctrl_word;
	wire [`DBS_DATA_W-1:0]      rd_word;
	wire                        addr_ram;
	wire                        addr_ok;
	wire [1:0]                  cap_stat;
	reg  [31:0]                 ram [0:`DBS_RAM_DEPTH-1];
	reg  [NCORE-1:0]            int_reg;

	assign is_dbus   = (ir_reg == `DBS_IR_DBUS);
	assign is_ctrl   = (ir_reg == `DBS_IR_DTMCTRL);
	assign sticky    = (stat_reg == `DBS_ST_FAIL) | (stat_reg == `DBS_ST_BUSY);
	assign cap_stat  = sticky ? stat_reg : busy_reg ? `DBS_ST_BUSY
		: (err_reg ? `DBS_ST_FAIL : `DBS_ST_OK);
	assign sh_op     = dr_sh_reg[1:0];
	assign start     = tck_rise & (tap_reg == S_UPDR) & is_dbus & ~sticky & ~busy_reg
		& ((sh_op == `DBS_OP_READ) | (sh_op == `DBS_OP_WRITE));
	assign bus_reset = tck_rise & (tap_reg == S_UPDR) & is_ctrl & dr_sh_reg[`DBS_RESET_BIT];
	assign done      = busy_reg & (cnt_reg == 8'h00);
	assign do_write  = done & (bop_reg == `DBS_OP_WRITE) & addr_ok;
	assign bus_busy  = busy_reg;
	assign ctrl_word = {15'h0, 1'b0, 1'b0, ABITS[5:4], `DBS_IDLE_CYCLES, stat_reg,
		ABITS[3:0], `DBS_VERSION};
	assign addr_ram  = (baddr_reg < `DBS_RAM_DEPTH);
	assign addr_ok   = addr_ram | (baddr_reg == `DBS_A_MODCTRL) | (baddr_reg == `DBS_A_HALTSUM);
	assign rd_word   = addr_ram ? {int_reg[sel_core], 1'b0, ram[baddr_reg[`DBS_RAM_AW-1:0]]}
		: (baddr_reg == `DBS_A_MODCTRL)
		? {int_reg[sel_core], 1'b0, {(32-SEL_W){1'b0}}, sel_core}
		: {int_reg[sel_core], 1'b0, {(32-NCORE){1'b0}}, core_halted};

	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			tap_reg    <= S_TLR;
			ir_reg     <= `DBS_IR_RESET;
			ir_sh_reg  <= {`DBS_IR_W{1'b0}};
			dr_sh_reg  <= {DBUS_W{1'b0}};
			stat_reg   <= `DBS_ST_OK;
			err_reg    <= 1'b0;
			tdo        <= 1'b0;
			tdo_oe     <= 1'b0;
		end
		else
		begin
			if (tck_rise)
			begin
				tap_reg <= tap_next;
				case (tap_reg)
					S_TLR:   ir_reg <= `DBS_IR_RESET;
					S_CAPIR: ir_sh_reg <= 5'h01;
					S_SHIR:  ir_sh_reg <= {tdi_lvl_reg, ir_sh_reg[`DBS_IR_W-1:1]};
					S_UPIR:  ir_reg <= ir_sh_reg;
					S_CAPDR:
					begin
						if (is_dbus)
						begin
							dr_sh_reg <= {baddr_reg, result_reg, cap_stat};
							stat_reg  <= cap_stat;
						end
						else if (is_ctrl)
							dr_sh_reg <= {{(DBUS_W-`DBS_CTRL_W){1'b0}}, ctrl_word};
						else
							dr_sh_reg <= {DBUS_W{1'b0}};
					end
					S_SHDR:
					begin
						if (is_dbus)
							dr_sh_reg <= {tdi_lvl_reg, dr_sh_reg[DBUS_W-1:1]};
						else if (is_ctrl)
							dr_sh_reg <= {{(DBUS_W-`DBS_CTRL_W){1'b0}}, tdi_lvl_reg,
								dr_sh_reg[`DBS_CTRL_W-1:1]};
						else
							dr_sh_reg <= {{(DBUS_W-1){1'b0}}, tdi_lvl_reg};
					end
					default: ;
				endcase
				if (bus_reset)
				begin
					stat_reg <= `DBS_ST_OK;
					err_reg  <= 1'b0;
				end
			end
			if (done)
				err_reg <= ~addr_ok;
			if (tck_fall)
			begin
				tdo_oe <= (tap_reg == S_SHDR) | (tap_reg == S_SHIR);
				tdo    <= (tap_reg == S_SHIR) ? ir_sh_reg[0] : dr_sh_reg[0];
			end
		end
	end

	// ****************************************
	// Debug bus engine
	// ****************************************
	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			busy_reg   <= 1'b0;
			cnt_reg    <= 8'h00;
			bop_reg    <= `DBS_OP_NOP;
			baddr_reg  <= {ADDR_W{1'b0}};
			bwdata_reg <= {`DBS_DATA_W{1'b0}};
			result_reg <= {`DBS_DATA_W{1'b0}};
			sel_core   <= {SEL_W{1'b0}};
		end
		else
		begin
			if (start)
			begin
				busy_reg   <= 1'b1;
				cnt_reg    <= BUS_CNT - 8'h01;
				bop_reg    <= sh_op;
				baddr_reg  <= dr_sh_reg[DBUS_W-1:`DBS_DATA_W+2];
				bwdata_reg <= dr_sh_reg[`DBS_DATA_W+1:2];
			end
			else if (done)
			begin
				busy_reg   <= 1'b0;
				result_reg <= addr_ok ? rd_word : {`DBS_DATA_W{1'b0}};
				if (do_write && (baddr_reg == `DBS_A_MODCTRL))
					sel_core <= bwdata_reg[SEL_W-1:0];
			end
			else if (busy_reg)
				cnt_reg <= cnt_reg - 8'h01;
		end
	end

	// ****************************************
	// Scratch RAM
	// ****************************************
	always @(posedge clock)
	begin
		if (do_write && addr_ram)
			ram[baddr_reg[`DBS_RAM_AW-1:0]] <= bwdata_reg[31:0];
		else if (core_ram_we)
			ram[core_ram_addr] <= core_ram_wdata;
		core_ram_rdata <= ram[core_ram_addr];
	end

	// ****************************************
	// Per-core interrupt, halt and resume
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < NCORE; gi = gi + 1)
		begin : g_core
			wire set_int;
			assign set_int = do_write & bwdata_reg[`DBS_INT_BIT] & (sel_core == gi);
			always @(posedge clock or negedge nrst)
			begin
				if (!nrst)
				begin
					int_reg[gi]        <= 1'b0;
					core_debug_int[gi] <= 1'b0;
					core_save_regs[gi] <= 1'b0;
					core_resume[gi]    <= 1'b0;
					core_wait[gi]      <= 1'b0;
				end
				else
				begin
					if (set_int)
						int_reg[gi] <= 1'b1;
					else if (core_at_resume[gi])
						int_reg[gi] <= 1'b0;
					core_debug_int[gi] <= set_int | (int_reg[gi] & ~core_at_resume[gi]);
					core_save_regs[gi] <= set_int & ~int_reg[gi];
					core_resume[gi]    <= core_at_resume[gi] & ~core_halted[gi];
					if (set_int)
						core_wait[gi] <= 1'b0;
					else if (core_at_resume[gi] && core_halted[gi])
						core_wait[gi] <= 1'b1;
				end
			end
		end
	endgenerate

endmodule // dbs_transport

// ===== dbs_consts.vh
// Constants for the scan debug transport and its debug module unit.
// Assumes one clock domain; scan pins are sampled, not used as clocks.
`ifndef DBS_CONSTS_VH
`define DBS_CONSTS_VH

// ****************************************
// Instruction codes
// ****************************************
`define DBS_IR_W          5
`define DBS_IR_RESET      5'h01
`define DBS_IR_DTMCTRL    5'h10
`define DBS_IR_DBUS       5'h11

// ****************************************
// Operation codes and status
// ****************************************
`define DBS_OP_NOP        2'h0
`define DBS_OP_READ       2'h1
`define DBS_OP_WRITE      2'h2
`define DBS_ST_OK         2'h0
`define DBS_ST_FAIL       2'h2
`define DBS_ST_BUSY       2'h3

// ****************************************
// Field positions
// ****************************************
`define DBS_DATA_W        34
`define DBS_INT_BIT       33
`define DBS_RESET_BIT     16
`define DBS_CTRL_W        32
`define DBS_VERSION       4'h0

// ****************************************
// Debug bus map
// ****************************************
`define DBS_RAM_AW        4
`define DBS_RAM_DEPTH     16
`define DBS_A_MODCTRL     5'h10
`define DBS_A_HALTSUM     5'h11

// ****************************************
// Timing
// ****************************************
`define DBS_CLOCK_MHZ     50
`define DBS_BUS_TIME_NS   40
`define DBS_BUS_CYCLES    ((`DBS_BUS_TIME_NS * `DBS_CLOCK_MHZ + 999) / 1000)
`define DBS_IDLE_CYCLES   3'h1

`endif

// ===== dbs_transport_assertions.sv
// Checker for the transport's core-side outputs and debug-bus busy flag.
// Assumes one clock domain; bound to every transport instance below.
module dbs_transport_chk #(
	parameter SEL_W   = 2,
	parameter NCORE   = 4,
	parameter BUS_CYC = 2
) (
	input wire logic             clock,
	input wire logic             nrst,
	input wire logic [NCORE-1:0] core_halted,
	input wire logic [NCORE-1:0] core_at_resume,
	input wire logic [NCORE-1:0] core_debug_int,
	input wire logic [NCORE-1:0] core_save_regs,
	input wire logic [NCORE-1:0] core_resume,
	input wire logic [NCORE-1:0] core_wait,
	input wire logic [SEL_W-1:0] sel_core,
	input wire logic             bus_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Busy length counter and properties
	// ****
	int busy_n;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	always_ff @(posedge clock or negedge nrst)
		if (!nrst)
			busy_n <= 0;
		else
			busy_n <= bus_busy ? busy_n + 1 : 0;
	save_on_raise_a:
	assert property (core_save_regs == (core_debug_int & ~$past(core_debug_int)))
		else $error("save pulse not tied to interrupt rise");
	int_cause_a:
	assert property ((core_debug_int & ~$past(core_debug_int)) != 0
		|-> $past(bus_busy) || $past(bus_busy, 2)) else $error("interrupt rose without bus op");
	int_target_a:
	assert property ((core_debug_int & ~$past(core_debug_int)) != 0
		|-> (core_debug_int & ~$past(core_debug_int)) == (NCORE'(1) << $past(sel_core)))
		else $error("interrupt rose on unselected core");
	int_clear_a:
	assert property ((core_at_resume & core_debug_int) != 0 && !bus_busy && !$past(bus_busy)
		|=> (core_debug_int & $past(core_at_resume)) == 0) else $error("interrupt not cleared");
	resume_pulse_a:
	assert property (core_resume == $past(core_at_resume & ~core_halted))
		else $error("resume pulse wrong");
	park_wait_a:
	assert property ((core_at_resume & core_halted) != 0 |=> (core_wait
		& $past(core_at_resume & core_halted)) == $past(core_at_resume & core_halted))
		else $error("halted core not parked");
	busy_len_a:
	assert property ($fell(bus_busy) |-> busy_n == BUS_CYC) else $error("bus op length wrong");
	sel_change_a:
	assert property ($changed(sel_core) |-> $past(bus_busy) || $past(bus_busy, 2))
		else $error("core select changed outside bus op");
	cover property (core_save_regs != 0);
	cover property (core_resume != 0);
	cover property (core_wait != 0);
endmodule // dbs_transport_chk

bind dbs_transport dbs_transport_chk #(.SEL_W(SEL_W), .NCORE(NCORE), .BUS_CYC(BUS_CYC)) chk_inst (
	.clock(clock), .nrst(nrst), .core_halted(core_halted), .core_at_resume(core_at_resume),
	.core_debug_int(core_debug_int), .core_save_regs(core_save_regs), .core_resume(core_resume),
	.core_wait(core_wait), .sel_core(sel_core), .bus_busy(bus_busy));

// ===== dbs_probe.sv
// Debugger probe model: walks the scan state machine and shifts registers.
// Assumes the caller starts it 1 ns after a clock edge; scan clock stands low between frames.
module dbs_probe (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	timeunit 1ns;
	timeprecision 1ns;
	int idle_n = 1;
	initial {tck, tms, tdi} = 3'b010;
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#80;
		q = tdo;
		tck = 1'b1;
		#80;
		tck = 1'b0;
	endtask
	task automatic to_idle;
		logic q;
		repeat (5) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
	task automatic scan(input logic ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic q;
		dout = '0;
		step(1'b1, ~tdi, q);
		if (ir)
			step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
		step(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, ~tdi, q);
		repeat (idle_n) step(1'b0, ~tdi, q);
		tdi = ~tdi;
	endtask
endmodule // dbs_probe

// ===== tb_top.sv
// Bench for the scan debug transport: probe model on the scan pins, bench plays the cores.
// Assumes the probe model and the transport checker are compiled first.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 1'b0, nrst = 1'b0, ram_we = 1'b0;
	logic        tck, tms, tdi, tdo, oe, busy;
	logic [3:0]  halted = 4'h0, at_res = 4'h0, ram_a = 4'h0, dint, save, res, park;
	logic [31:0] ram_wd = 32'h0, ram_rd, w, old;
	logic [1:0]  sel;
	logic [63:0] o;
	logic [31:0] mem [16];
	int          seed = 62697, mismatches = 0, total_checks = 0;
	always #10 clock = ~clock;
	dbs_transport #(.BUS_CYC(2)) dbs_transport_inst (.clock(clock), .nrst(nrst), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(oe), .core_halted(halted), .core_at_resume(at_res),
		.core_ram_addr(ram_a), .core_ram_we(ram_we), .core_ram_wdata(ram_wd), .core_ram_rdata(ram_rd),
		.core_debug_int(dint), .core_save_regs(save), .core_resume(res), .core_wait(park),
		.sel_core(sel), .bus_busy(busy));
	dbs_probe dbs_probe_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	// ****
	// Shared tasks
	// ****
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic dbus(input logic [4:0] a, input logic [33:0] d, input logic [1:0] op);
		dbs_probe_inst.scan(1'b0, 41, {23'h0, a, d, op}, o);
		cyc(4);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic ret(input logic h);
		halted[2] = h;
		at_res = 4'h4;
		cyc(1);
		at_res = 4'h0;
	endtask
	initial
	begin
		#1ms;
		mismatches++;
		stop_test();
	end
	// ****
	// Main sequence
	// ****
	initial
	begin
		cyc(20);
		nrst = 1'b1;
		dbs_probe_inst.to_idle();
		dbs_probe_inst.scan(1'b1, 5, 64'h11, o);
		chk(oe, 1'b0);
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 16; i++)
			begin
				w = $random(seed);
				dbus(i[4:0], {2'h0, w}, 2'h2);
				if (p == 1 && i > 0)
					chk(o[40:0], {5'(i - 1), 2'h0, old, 2'h0});
				old = mem[i];
				mem[i] = w;
			end
		dbus(5'h0f, 34'h3_ffff_ffff, 2'h1);
		chk(o[35:0], {2'h0, old, 2'h0});
		dbus(5'h00, {2'h0, w}, 2'h0);
		chk(o[40:0], {5'h0f, 2'h0, mem[15], 2'h0});
		chk(ram_rd, mem[0]);
		w = $random(seed);
		{ram_a, ram_wd, ram_we} = {4'h5, w, 1'b1};
		cyc(1);
		ram_we = 1'b0;
		mem[5] = w;
		dbus(5'h10, 34'h2, 2'h2);
		chk(sel, 2'h2);
		w = $random(seed);
		dbus(5'h00, {2'h2, w}, 2'h2);
		chk(dint, 4'h4);
		dbus(5'h00, 34'h0, 2'h1);
		dbus(5'h00, 34'h0, 2'h1);
		chk(o[35], 1'b1);
		ret(1'b0);
		chk({res, dint}, 8'h40);
		dbus(5'h00, 34'h0, 2'h1);
		dbus(5'h00, 34'h0, 2'h0);
		chk(o[35:2], {2'h0, w});
		halted = 4'($random(seed)) | 4'h4;
		dbus(5'h01, {2'h2, w}, 2'h2);
		ret(1'b1);
		chk({park, res}, 8'h40);
		dbus(5'h11, 34'h0, 2'h1);
		dbus(5'h00, 34'h0, 2'h0);
		chk(o[35:2], {30'h0, halted});
		dbus(5'h01, {2'h2, w}, 2'h2);
		ret(1'b0);
		chk(res, 4'h4);
		dbus(5'h1f, 34'h0, 2'h1);
		dbus(5'h05, {2'h0, ~w}, 2'h2);
		chk(o[1:0], 2'h2);
		dbus(5'h00, 34'h0, 2'h0);
		chk(o[1:0], 2'h2);
		dbs_probe_inst.scan(1'b1, 5, 64'h10, o);
		dbs_probe_inst.scan(1'b0, 32, 64'h1_0000, o);
		chk(o[14:0], 15'h0650);
		dbs_probe_inst.scan(1'b1, 5, 64'h11, o);
		dbs_probe_inst.idle_n = 3;
		dbus(5'h05, 34'h0, 2'h1);
		dbus(5'h00, 34'h0, 2'h0);
		chk(o[35:0], {2'h0, mem[5], 2'h0});
		stop_test();
	end
endmodule // tb_top
